// ---- pkg/oie_consts.vh ----
// constants for the upper interrupt event block
`ifndef OIE_CONSTS_VH
`define OIE_CONSTS_VH
`define OIE_OFS_SET        8'h80
`define OIE_OFS_CLEAR      8'h84
`define OIE_OFS_MASK       8'h88
`define OIE_OFS_STATUS     8'h8c
`define OIE_OFS_CTRL       8'h90
`define OIE_OFS_PHYDATA    8'h94
`define OIE_OFS_TIMER      8'h98
`define OIE_ADDR_W         8
`define OIE_BIT_SOFT       29
`define OIE_BIT_TARDY      27
`define OIE_BIT_PHYREG     26
`define OIE_BIT_LONG       25
`define OIE_BIT_FATAL      24
`define OIE_BIT_MISMATCH   23
`define OIE_EVT_MASK       32'h2f800000
`define OIE_SW_MASK        32'h20000000
`define OIE_CTRL_TARDY_EN  0
`define OIE_CTRL_LEADER    1
`define OIE_SEC_HI         31
`define OIE_SEC_LO         25
`define OIE_TICK_HI        24
`define OIE_TICK_LO        12
`define OIE_CYC_LIMIT_NS   125000
`define OIE_CLK_NS         10
`define OIE_CYC_LIMIT_CYC  (`OIE_CYC_LIMIT_NS / `OIE_CLK_NS)
`define OIE_CNT_W          14
`endif

// ---- design/oie_edge.v ----
// rising edge detector for one synchronised event source
module oie_edge (
  input  wire CLK,
  input  wire ARST_N,
  input  wire level_in,
  output wire rise
);
  reg last_reg;
  always @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      last_reg <= 1'b0;
    else
      last_reg <= level_in;
  end
  assign rise = level_in & ~last_reg;
endmodule

// ---- design/oie_sync.v ----
// two flip-flop synchroniser for one pin level
module oie_sync (
  input  wire CLK,
  input  wire ARST_N,
  input  wire d_in,
  output wire q_out
);
  reg s1_reg;
  reg s2_reg;
  always @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
    end
    else
    begin
      s1_reg <= d_in;
      s2_reg <= s1_reg;
    end
  end
  assign q_out = s2_reg;
endmodule

// ---- design/oie_top.v ----
// upper interrupt event bits 31..23 with wishbone slave
// Summary of operation
// - a flag sets on a source rising edge or a set-address write of one.
// - a flag clears only on a clear-address write of one.
// - event reads return flags ANDed with the interrupt mask.
// - bits 31, 30 and 28 always read zero.
// - bit 29 is software raised only, set and cleared by writes.
// - with late-ack enable, fifo data, busy response unit or late ack set bit 27.
// - an arriving phy register byte sets bit 26 and is readable in bits 23..16.
// - leader enabled, a cycle start sent more than 125 us after the last one with no gap end between sets bit 25.
// - the overlong cycle event clears the cycle leader enable bit.
// - any error halting a subunit sets bit 24.
// - while bit 24 is set, a context event leaves the context event flag unset.
// - received cycle start differing from local seconds or tick sets bit 23.
`include "oie_consts.vh"
module oie_top (
  input  wire        CLK,
  input  wire        ARST_N,
  input  wire        WB_CYC_I,
  input  wire        WB_STB_I,
  input  wire        WB_WE_I,
  input  wire [7:0]  WB_ADR_I,
  input  wire [3:0]  WB_SEL_I,
  input  wire [31:0] WB_DAT_I,
  output reg  [31:0] WB_DAT_O,
  output reg         WB_ACK_O,
  input  wire        RX_FIFO_PENDING,
  input  wire        PHYS_RESP_BUSY,
  input  wire        LATE_ACK_SENT,
  input  wire        PHY_BYTE_VALID,
  input  wire [7:0]  PHY_BYTE,
  input  wire        CYCLE_START_TX,
  input  wire        SUBACTION_GAP_END,
  input  wire        SUBUNIT_HALT,
  input  wire        CTX_EVENT,
  input  wire        CYCLE_START_RX,
  input  wire [31:0] RX_CYCLE_TIME,
  input  wire [31:0] LOCAL_CYCLE_TIME,
  output reg         CTX_EVENT_FLAG,
  output reg         CYCLE_LEADER_ENABLE,
  output reg         IRQ
);
  // ****************************************
  // input synchronisers
  // ****************************************
  wire [8:0] raw_in;
  wire [8:0] syn;
  assign raw_in = {CYCLE_START_RX, CTX_EVENT, SUBUNIT_HALT, SUBACTION_GAP_END,
                   CYCLE_START_TX, PHY_BYTE_VALID, LATE_ACK_SENT, PHYS_RESP_BUSY,
                   RX_FIFO_PENDING};
  genvar gi;
  generate
    for (gi = 0; gi < 9; gi = gi + 1)
    begin : g_sync
      oie_sync u_sync (
        .CLK    (CLK),
        .ARST_N (ARST_N),
        .d_in   (raw_in[gi]),
        .q_out  (syn[gi])
      );
    end
  endgenerate
  // byte and time words are sampled only after their strobes settle,
  // so two plain register stages, matching the strobe synchronisers, serve the data buses
  reg [7:0]  phy_byte_s1_reg;
  reg [7:0]  phy_byte_s2_reg;
  reg [31:0] rx_time_s1_reg;
  reg [31:0] rx_time_s2_reg;
  reg [31:0] loc_time_s1_reg;
  reg [31:0] loc_time_s2_reg;
  always @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      phy_byte_s1_reg <= 8'h00;
      phy_byte_s2_reg <= 8'h00;
      rx_time_s1_reg  <= 32'h00000000;
      rx_time_s2_reg  <= 32'h00000000;
      loc_time_s1_reg <= 32'h00000000;
      loc_time_s2_reg <= 32'h00000000;
    end
    else
    begin
      phy_byte_s1_reg <= PHY_BYTE;
      phy_byte_s2_reg <= phy_byte_s1_reg;
      rx_time_s1_reg  <= RX_CYCLE_TIME;
      rx_time_s2_reg  <= rx_time_s1_reg;
      loc_time_s1_reg <= LOCAL_CYCLE_TIME;
      loc_time_s2_reg <= loc_time_s1_reg;
    end
  end
  // ****************************************
  // edge detection
  // ****************************************
  wire [8:0] rise;
  generate
    for (gi = 0; gi < 9; gi = gi + 1)
    begin : g_edge
      oie_edge u_edge (
        .CLK      (CLK),
        .ARST_N   (ARST_N),
        .level_in (syn[gi]),
        .rise     (rise[gi])
      );
    end
  endgenerate
  // ****************************************
  // registers and bus decode
  // ****************************************
  reg  [31:0] flags_reg;
  reg  [31:0] flags_next;
  reg  [31:0] mask_reg;
  reg         tardy_en_reg;
  reg  [7:0]  phy_data_reg;
  reg         in_cycle_reg;
  reg  [`OIE_CNT_W-1:0] cyc_cnt_reg;
  wire        bus_req;
  wire        wr;
  wire        rd;
  wire [31:0] be_mask;
  wire [31:0] wdat;
  wire [31:0] masked_evt;
  assign bus_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  assign wr      = bus_req & WB_WE_I;
  assign rd      = bus_req & ~WB_WE_I;
  assign be_mask = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}}, {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
  assign wdat    = WB_DAT_I & be_mask;
  assign masked_evt = flags_reg & mask_reg & `OIE_EVT_MASK;
  // ****************************************
  // hardware event sources
  // ****************************************
  wire tardy_evt;
  wire long_evt;
  wire mismatch_evt;
  wire cyc_over;
  assign cyc_over = in_cycle_reg &
                    (cyc_cnt_reg >= `OIE_CYC_LIMIT_CYC);
  // each source is only a rising edge, a held level cannot re-set
  assign tardy_evt = tardy_en_reg & (rise[0] | rise[1] | rise[2]);
  assign long_evt  = CYCLE_LEADER_ENABLE & cyc_over & rise[4];
  assign mismatch_evt = rise[8] &
    ((rx_time_s2_reg[`OIE_SEC_HI:`OIE_SEC_LO] != loc_time_s2_reg[`OIE_SEC_HI:`OIE_SEC_LO]) |
     (rx_time_s2_reg[`OIE_TICK_HI:`OIE_TICK_LO] != loc_time_s2_reg[`OIE_TICK_HI:`OIE_TICK_LO]));
  always @*
  begin
    flags_next = flags_reg;
    if (wr && WB_ADR_I == `OIE_OFS_CLEAR)
      flags_next = flags_next & ~wdat;
    if (wr && WB_ADR_I == `OIE_OFS_SET)
      flags_next = flags_next | wdat;
    // hardware sets are applied last so they win over a same-cycle clear
    if (tardy_evt)
      flags_next[`OIE_BIT_TARDY] = 1'b1;
    if (rise[3])
      flags_next[`OIE_BIT_PHYREG] = 1'b1;
    if (long_evt)
      flags_next[`OIE_BIT_LONG] = 1'b1;
    if (rise[6])
      flags_next[`OIE_BIT_FATAL] = 1'b1;
    if (mismatch_evt)
      flags_next[`OIE_BIT_MISMATCH] = 1'b1;
    flags_next = flags_next & `OIE_EVT_MASK;
  end
  always @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      flags_reg           <= 32'h00000000;
      mask_reg            <= 32'h00000000;
      tardy_en_reg        <= 1'b0;
      CYCLE_LEADER_ENABLE <= 1'b0;
      phy_data_reg        <= 8'h00;
      in_cycle_reg        <= 1'b0;
      cyc_cnt_reg         <= {`OIE_CNT_W{1'b0}};
      CTX_EVENT_FLAG      <= 1'b0;
      IRQ                 <= 1'b0;
      WB_ACK_O            <= 1'b0;
      WB_DAT_O            <= 32'h00000000;
    end
    else
    begin
      flags_reg <= flags_next;
      IRQ       <= |(flags_next & mask_reg);
      WB_ACK_O  <= bus_req;
      if (rise[3])
        phy_data_reg <= phy_byte_s2_reg;
      // cycle timer runs from a sent cycle start to the gap end, and holds once it reaches the 125 us limit
      if (rise[4])
      begin
        in_cycle_reg <= 1'b1;
        cyc_cnt_reg  <= {`OIE_CNT_W{1'b0}};
      end
      else if (rise[5])
        in_cycle_reg <= 1'b0;
      else if (in_cycle_reg && !cyc_over)
        cyc_cnt_reg <= cyc_cnt_reg + 1'b1;
      // a context event is dropped while the fatal flag stands
      if (rise[7] && !flags_reg[`OIE_BIT_FATAL])
        CTX_EVENT_FLAG <= 1'b1;
      else if (wr && WB_ADR_I == `OIE_OFS_STATUS && WB_DAT_I[0])
        CTX_EVENT_FLAG <= 1'b0;
      if (wr && WB_ADR_I == `OIE_OFS_MASK)
        mask_reg <= (mask_reg & ~be_mask) | (wdat & `OIE_EVT_MASK);
      if (wr && WB_ADR_I == `OIE_OFS_CTRL && WB_SEL_I[0])
        tardy_en_reg <= WB_DAT_I[`OIE_CTRL_TARDY_EN];
      if (long_evt)
        CYCLE_LEADER_ENABLE <= 1'b0;
      else if (wr && WB_ADR_I == `OIE_OFS_CTRL && WB_SEL_I[0])
        CYCLE_LEADER_ENABLE <= WB_DAT_I[`OIE_CTRL_LEADER];
      if (rd)
      begin
        case (WB_ADR_I)
          `OIE_OFS_SET,
          `OIE_OFS_CLEAR:   WB_DAT_O <= masked_evt;
          `OIE_OFS_MASK:    WB_DAT_O <= mask_reg;
          `OIE_OFS_STATUS:  WB_DAT_O <= {31'h00000000, CTX_EVENT_FLAG};
          `OIE_OFS_CTRL:    WB_DAT_O <= {30'h00000000, CYCLE_LEADER_ENABLE, tardy_en_reg};
          `OIE_OFS_PHYDATA: WB_DAT_O <= {8'h00, phy_data_reg, 16'h0000};
          `OIE_OFS_TIMER:   WB_DAT_O <= {{(32-`OIE_CNT_W){1'b0}}, cyc_cnt_reg};
          default:          WB_DAT_O <= 32'h00000000;
        endcase
      end
      else
        WB_DAT_O <= 32'h00000000;
    end
  end
endmodule

// ---- verification/oie_sva.sv ----
// checker for bus timing and read values of the upper event block
`include "oie_consts.vh"
module oie_sva (
  input wire        CLK,
  input wire        ARST_N,
  input wire        WB_CYC_I,
  input wire        WB_STB_I,
  input wire        WB_WE_I,
  input wire [7:0]  WB_ADR_I,
  input wire [31:0] WB_DAT_O,
  input wire        WB_ACK_O,
  input wire        CYCLE_LEADER_ENABLE,
  input wire        IRQ
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // assertions
  // ****
  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  wire req = WB_CYC_I && WB_STB_I;
  wire evt = WB_ADR_I == `OIE_OFS_SET || WB_ADR_I == `OIE_OFS_CLEAR;
  wire bad = WB_ADR_I < `OIE_OFS_SET || WB_ADR_I > `OIE_OFS_TIMER;
  a_ack_next: assert property (req && !WB_ACK_O |=> WB_ACK_O) else $error("ack missing");
  a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack too long");
  a_ack_cause: assert property (WB_ACK_O |-> $past(req)) else $error("ack without request");
  a_dat_idle: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0) else $error("data outside ack");
  a_rsvd_zero: assert property (WB_ACK_O && evt |-> WB_DAT_O[31:30] == 2'h0 && !WB_DAT_O[28])
    else $error("reserved bit read high");
  a_unmapped_zero: assert property (WB_ACK_O && bad |-> WB_DAT_O == 32'h0)
    else $error("unmapped read not zero");
  a_leader_rise: assert property ($rose(CYCLE_LEADER_ENABLE) |->
    WB_ACK_O && WB_WE_I && WB_ADR_I == `OIE_OFS_CTRL) else $error("leader set without write");
  a_irq_fall: assert property ($fell(IRQ) |-> (WB_ACK_O && WB_WE_I) || $past(WB_ACK_O && WB_WE_I))
    else $error("irq dropped without write");
  cover property (WB_ACK_O && WB_WE_I);
  cover property ($rose(IRQ));
  cover property ($fell(CYCLE_LEADER_ENABLE));
endmodule
bind oie_top oie_sva chk_u (.CLK, .ARST_N, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I,
  .WB_DAT_O, .WB_ACK_O, .CYCLE_LEADER_ENABLE, .IRQ);

// ---- verification/ohci_interrupt_event_upper_tb_top.sv ----
// self-checking bench for the upper interrupt event block
`include "oie_consts.vh"
module ohci_interrupt_event_upper_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // stimulus and model
  // ****
  localparam logic [31:0] IMPL = 32'h2f800000;
  logic        CLK = '0;
  logic        ARST_N = '0;
  logic        cyc = '0;
  logic        we = '0;
  logic [7:0]  adr = '0;
  logic [31:0] wdat = '0;
  logic [31:0] rdat;
  logic [8:0]  ev = '0;
  logic [7:0]  pbyte = '0;
  logic [31:0] rxt = '0;
  logic [31:0] lct = '0;
  logic [31:0] flags = '0;
  logic [31:0] mask = '0;
  logic [31:0] seed = 32'he69c;
  logic [31:0] dif [4] = '{32'h1000, 32'h80000000, 32'h800, 32'h0};
  wire  [31:0] dat_o;
  wire         ack, ctx_flag, leader, irq;
  int          err_count = 0;
  int          compares = 0;
  always #5 CLK = ~CLK;
  // stb follows cyc: only classic single cycles are issued
  oie_top dut_u (.CLK, .ARST_N, .WB_CYC_I(cyc), .WB_STB_I(cyc), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(wdat), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
    .RX_FIFO_PENDING(ev[0]), .PHYS_RESP_BUSY(ev[1]), .LATE_ACK_SENT(ev[2]),
    .PHY_BYTE_VALID(ev[3]), .PHY_BYTE(pbyte), .CYCLE_START_TX(ev[4]),
    .SUBACTION_GAP_END(ev[5]), .SUBUNIT_HALT(ev[6]), .CTX_EVENT(ev[7]),
    .CYCLE_START_RX(ev[8]), .RX_CYCLE_TIME(rxt), .LOCAL_CYCLE_TIME(lct),
    .CTX_EVENT_FLAG(ctx_flag), .CYCLE_LEADER_ENABLE(leader), .IRQ(irq));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic print_verdict();
    if (err_count == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge CLK);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do
    begin
      @(posedge CLK);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      err_count++;
      print_verdict();
    end
    rdat = dat_o;
    cyc <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic rd_evt();
    wb(1'b0, `OIE_OFS_SET, 32'h0);
    chk(rdat, flags & mask & IMPL);
    chk({31'h0, irq}, {31'h0, |(flags & mask & IMPL)});
  endtask
  task automatic clrb(input int b);
    wb(1'b1, `OIE_OFS_CLEAR, 32'h1 << b);
    flags[b] = 1'b0;
  endtask
  // sources are held a few cycles so the synchroniser cannot miss them
  task automatic hit(input int i, input int b, input logic s, input logic keep);
    ev[i] <= 1'b1;
    repeat (6) @(posedge CLK);
    ev[i] <= keep;
    repeat (4) @(posedge CLK);
    if (s)
      flags[b] = 1'b1;
    rd_evt();
  endtask
  initial
  begin
    logic [31:0] d;
    logic [7:0]  a;
    repeat (12) @(posedge CLK);
    ARST_N <= 1'b1;
    wb(1'b1, `OIE_OFS_CLEAR, 32'hffffffff);
    for (int k = 0; k < 31; k++)
    begin
      d = k == 0 ? 32'hffffffff : rnd();
      a = k % 3 == 2 ? `OIE_OFS_SET : k % 3 == 1 ? `OIE_OFS_CLEAR : `OIE_OFS_MASK;
      wb(1'b1, a, d);
      if (a == `OIE_OFS_SET)
        flags |= d & IMPL;
      else if (a == `OIE_OFS_CLEAR)
        flags &= ~d;
      else
        mask = d & `OIE_EVT_MASK;
      rd_evt();
    end
    wb(1'b1, `OIE_OFS_MASK, 32'hffffffff);
    mask = `OIE_EVT_MASK;
    wb(1'b0, 8'h40, 32'h0);
    chk(rdat, 32'h0);
    wb(1'b1, `OIE_OFS_CTRL, 32'h1);
    hit(0, 27, 1'b1, 1'b1);
    clrb(27);
    rd_evt();
    ev[0] <= 1'b0;
    repeat (4) @(posedge CLK);
    for (int i = 0; i < 3; i++)
    begin
      hit(i, 27, 1'b1, 1'b0);
      clrb(27);
    end
    wb(1'b1, `OIE_OFS_CTRL, 32'h0);
    hit(1, 27, 1'b0, 1'b0);
    pbyte <= 8'(rnd());
    repeat (4) @(posedge CLK);
    hit(3, 26, 1'b1, 1'b0);
    wb(1'b0, `OIE_OFS_PHYDATA, 32'h0);
    chk({24'h0, rdat[23:16]}, {24'h0, pbyte});
    for (int j = 0; j < 4; j++)
    begin
      d = rnd();
      rxt <= d;
      lct <= d ^ dif[j];
      repeat (4) @(posedge CLK);
      hit(8, 23, j < 2, 1'b0);
      clrb(23);
    end
    hit(6, 24, 1'b1, 1'b0);
    hit(7, 0, 1'b0, 1'b0);
    chk({31'h0, ctx_flag}, 32'h0);
    clrb(24);
    hit(7, 0, 1'b0, 1'b0);
    chk({31'h0, ctx_flag}, 32'h1);
    wb(1'b1, `OIE_OFS_CTRL, 32'h2);
    chk({31'h0, leader}, 32'h1);
    hit(4, 25, 1'b0, 1'b0);
    hit(5, 25, 1'b0, 1'b0);
    repeat (12600) @(posedge CLK);
    hit(4, 25, 1'b0, 1'b0);
    repeat (12500) @(posedge CLK);
    hit(4, 25, 1'b1, 1'b0);
    chk({31'h0, leader}, 32'h0);
    print_verdict();
  end
endmodule
